/* src/rtcic_pkg.sv */
package rtcic_pkg;

   // Register indices on the serial register port
   localparam logic [3:0] ADDR_SECONDS = 4'h0;
   localparam logic [3:0] ADDR_CTRL1   = 4'hE;
   localparam logic [3:0] ADDR_CTRL2   = 4'hF;

   // Control register 1 field positions
   localparam int C1_WEEKDAY_EN = 7;
   localparam int C1_DAILY_EN   = 6;
   localparam int C1_HOUR24     = 5;
   localparam int C1_SPARE3     = 4;
   localparam int C1_TEST       = 3;

   // Control register 2 field positions
   localparam int C2_VSEL   = 7;
   localparam int C2_VLOW   = 6;
   localparam int C2_SPARE1 = 5;
   localparam int C2_HALT   = 4;
   localparam int C2_SPARE2 = 3;
   localparam int C2_PER    = 2;
   localparam int C2_WAFL   = 1;
   localparam int C2_DAFL   = 0;

   // Reset values
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [7:0] CTRL2_RST = 8'h10;

   // Periodic select codes
   localparam logic [2:0] SEL_OFF   = 3'h0;
   localparam logic [2:0] SEL_FIXED = 3'h1;
   localparam logic [2:0] SEL_2HZ   = 3'h2;
   localparam logic [2:0] SEL_1HZ   = 3'h3;
   localparam logic [2:0] SEL_SEC   = 3'h4;
   localparam logic [2:0] SEL_MIN   = 3'h5;
   localparam logic [2:0] SEL_HOUR  = 3'h6;
   localparam logic [2:0] SEL_MONTH = 3'h7;

   // Crystal time base
   localparam int          XTAL_HZ     = 32768;
   localparam logic [15:0] DIV_LAST    = 16'h7FFF;
   localparam logic [15:0] DIV_HALF    = 16'h4000;
   localparam int          ADJ_PERIOD  = 20;
   localparam logic [4:0]  ADJ_LAST    = 5'h13;

   // Timing, in nanoseconds and microseconds as specified
   localparam int CLK_NS         = 50;
   localparam int SEC_DELAY_NS   = 92000;
   localparam int ALARM_DELAY_NS = 61000;
   localparam int ADJ_MAX_US     = 3784;
   // Least times round up to whole clock cycles
   localparam int SEC_DELAY_CYC   = (SEC_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam int ALARM_DELAY_CYC = (ALARM_DELAY_NS + CLK_NS - 1) / CLK_NS;
   // Longest correction rounds down to whole crystal ticks
   localparam int ADJ_MAX_TICKS   = (ADJ_MAX_US * XTAL_HZ) / 1000000;

   typedef struct packed {
      logic       weekday_alarm_enable;
      logic       daily_alarm_enable;
      logic       hour24;
      logic       spare_bit_three;
      logic       test;
      logic [2:0] periodic_select;
   } rtcic_ctrl1_t;

   typedef struct packed {
      logic voltage_threshold_select;
      logic low_voltage_flag;
      logic spare_bit_one;
      logic osc_halt_flag;
      logic spare_bit_two;
      logic periodic_irq_flag;
      logic weekday_alarm_flag;
      logic daily_alarm_flag;
   } rtcic_ctrl2_t;

endpackage : rtcic_pkg

/* src/rtcic_delay.sv */
`timescale 1ns/10ps
// One-shot: a start pulse yields a done pulse CYCLES clocks later
module rtcic_delay #(
   parameter int CYCLES = 16
) (
   input  wire logic clk,    // System clock
   input  wire logic rst_b,  // Async reset, active low
   input  wire logic start,  // Begin timing
   input  wire logic abort,  // Drop a pending timing
   output logic      busy,   // Timing in progress
   output logic      done    // One-cycle pulse at expiry
);
   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] cnt_r;

   if (CYCLES < 2) begin : g_cycles_check
      $error("rtcic_delay: CYCLES must be at least 2");
   end

   assign busy = (cnt_r != '0);

   // A start during a pending count is ignored: one event per window
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= '0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (abort) begin
            cnt_r <= '0;
         end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
            if (cnt_r == CW'(1)) begin
               done <= 1'b1;
            end
         end else if (start) begin
            cnt_r <= CW'(CYCLES - 1);
         end
      end
   end

endmodule : rtcic_delay

/* src/rtcic_ctrl.sv */
`timescale 1ns/10ps
// What this block does
// [R1] Three spare bits read back as written, forced 0 when halt flag sets.
// [R2] Test bit: 0 normal, 1 factory test; software keeps it 0.
// [R3] Select 0 output A high, 1 low, 2 2Hz, 3 1Hz at 50% duty.
// [R4] Select 4-7 level mode: per second, minute, hour, month boundary.
// [R5] Pulse mode: seconds advance about 92 us after output falling edge.
// [R6] Writing seconds clears sub-second divider and drives pulse output low.
// [R7] Level mode: output falling edge coincides with seconds increment.
// [R8] Adjustment alters one period in every 20 seconds by at most 3.784 ms.
// [R9] Threshold select: 0 gives 2.1 V, 1 gives 1.6 V.
// [R10] Low-voltage flag sets below threshold, holds, monitoring continues meanwhile.
// [R11] Writing 0 clears low-voltage flag unless supply is still below threshold; 1 ignored.
// [R12] Halt flag sets when oscillation stops and stays set after restart.
// [R13] Halt set clears adjust and control registers, stops irqs, enables subclock.
// [R14] Writing 0 clears halt flag and re-arms detection; 1 ignored.
// [R15] Periodic flag reads 1 exactly while periodic generator pulls output A low.
// [R16] Level mode: writing 0 to periodic flag releases output A until next event.
// [R17] Enabled alarm flag sets about 61 us after a time match.
// [R18] Writing 0 to alarm flag clears it and releases its output; 1 ignored.
// [R19] Alarm flag reads 0 whenever its enable is 0.
// [R20] Weekday alarm drives output B, daily alarm drives output A.
// [R21] Control register 2 layout D7..D0; after power-on only halt flag set.
// [R22] Host should poll the halt flag to detect corrupted settings.
// [R23] Alarm enable bits turn alarm compare and irq on; default off.
// [R24] Control register 1 at index E: select D2-D0, test D3, spare D4.
// [R25] Hardware set beats a simultaneous software clear of the same flag.
module rtcic_ctrl #(
   parameter int SEC_DELAY   = rtcic_pkg::SEC_DELAY_CYC,
   parameter int ALARM_DELAY = rtcic_pkg::ALARM_DELAY_CYC
) (
   input  wire logic              CLK,              // 20 MHz system clock
   input  wire logic              RST_B,            // Async reset, active low (power-on)
   input  wire logic [3:0]        REG_ADDR,         // Register index from serial engine
   input  wire logic              REG_WR,           // Write strobe, one cycle
   input  wire logic [7:0]        REG_WDATA,        // Write data
   output logic      [7:0]        REG_RDATA,        // Read data for REG_ADDR, one cycle late
   input  wire logic              OSC_TICK,         // 32.768 kHz crystal tick, one cycle
   input  wire logic              OSC_HALT,         // Oscillation stopped detector
   input  wire logic              SUPPLY_BELOW_HI,  // Supply below 2.1 V
   input  wire logic              SUPPLY_BELOW_LO,  // Supply below 1.6 V
   input  wire logic              ALARM_W_MATCH,    // Weekday alarm compare hit, pulse
   input  wire logic              ALARM_D_MATCH,    // Daily alarm compare hit, pulse
   input  wire logic              NEXT_MIN,         // Next second increment reaches :00
   input  wire logic              NEXT_HOUR,        // Next second increment reaches 00:00
   input  wire logic              NEXT_MONTH,       // Next increment reaches day 1 00:00:00
   input  wire logic signed [7:0] ADJ_STEP,         // Crystal ticks added per 20 s window
   output logic                   SEC_INC,          // Seconds counter advance, pulse
   output logic                   IRQ_A_OE,         // Pull irq_out_a low
   output logic                   IRQ_B_OE,         // Pull irq_out_b low
   output logic                   SUB_CLK_EN,       // sub_clock_out enable
   output logic                   ADJ_CLEAR,        // Clear adjust register, pulse
   output logic                   TEST_MODE,        // Factory test mode
   output logic                   HOUR24_MODE       // 24-hour mode select
);
   rtcic_pkg::rtcic_ctrl1_t c1_r;
   rtcic_pkg::rtcic_ctrl2_t c2_r;
   logic [15:0]             div_r;
   logic [15:0]             div_top;
   logic [4:0]              sec20_r;
   logic                    per_low_r;
   logic                    per_low_nxt;
   logic                    halt_set;
   logic                    wr_c1;
   logic                    wr_c2;
   logic                    wr_sec;
   logic                    wrap;
   logic                    pulse_mode;
   logic                    level_mode;
   logic                    level_evt;
   logic                    below;
   logic signed [8:0]       adj_clamped;
   logic                    adj_win;
   logic                    sec_dly_done;
   logic                    wa_done;
   logic                    da_done;
   logic                    wa_busy;
   logic                    da_busy;
   logic                    waf_nxt;
   logic                    daf_nxt;

   if (SEC_DELAY < 2 || ALARM_DELAY < 2) begin : g_delay_check
      $error("rtcic_ctrl: delays must be at least 2 cycles");
   end

   assign wr_c1      = REG_WR && (REG_ADDR == rtcic_pkg::ADDR_CTRL1);
   assign wr_c2      = REG_WR && (REG_ADDR == rtcic_pkg::ADDR_CTRL2);
   assign wr_sec     = REG_WR && (REG_ADDR == rtcic_pkg::ADDR_SECONDS);
   assign halt_set   = OSC_HALT && !c2_r.osc_halt_flag; // [R12]
   assign pulse_mode = (c1_r.periodic_select == rtcic_pkg::SEL_2HZ) ||
                       (c1_r.periodic_select == rtcic_pkg::SEL_1HZ);
   assign level_mode = c1_r.periodic_select[2];
   // Monitoring runs on while the flag is held
   assign below = c2_r.voltage_threshold_select ? SUPPLY_BELOW_LO : SUPPLY_BELOW_HI; // [R9]

   // Correction limited to the largest allowed step per window
   always_comb begin
      adj_clamped = 9'(ADJ_STEP);
      if (adj_clamped > 9'(rtcic_pkg::ADJ_MAX_TICKS)) begin
         adj_clamped = 9'(rtcic_pkg::ADJ_MAX_TICKS); // [R8]
      end else if (adj_clamped < -9'(rtcic_pkg::ADJ_MAX_TICKS)) begin
         adj_clamped = -9'(rtcic_pkg::ADJ_MAX_TICKS); // [R8]
      end
   end
   assign adj_win = (sec20_r == rtcic_pkg::ADJ_LAST) && (ADJ_STEP != 8'sh00);
   assign div_top = adj_win ? 16'(rtcic_pkg::DIV_LAST + 16'(adj_clamped)) : rtcic_pkg::DIV_LAST; // [R8]
   assign wrap    = OSC_TICK && (div_r >= div_top) && !wr_sec;

   // Sub-second divider; a seconds write restarts the second
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         div_r   <= 16'h0000;
         sec20_r <= 5'h00;
      end else if (wr_sec) begin
         div_r <= 16'h0000; // [R6]
      end else if (OSC_TICK) begin
         if (wrap) begin
            div_r   <= 16'h0000;
            sec20_r <= (sec20_r == rtcic_pkg::ADJ_LAST) ? 5'h00 : sec20_r + 5'h01; // [R8]
         end else begin
            div_r <= div_r + 16'h0001;
         end
      end
   end

   // Pulse mode holds the increment back so the falling edge leads it
   rtcic_delay #(
      .CYCLES (SEC_DELAY)
   ) u_sec_delay (
      .clk   (CLK),
      .rst_b (RST_B),
      .start (wrap && pulse_mode), // [R5]
      .abort (wr_sec),
      .busy  (),
      .done  (sec_dly_done)
   );

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         SEC_INC <= 1'b0;
      end else begin
         SEC_INC <= pulse_mode ? sec_dly_done : wrap; // [R5] [R7]
      end
   end

   always_comb begin
      case (c1_r.periodic_select)
         rtcic_pkg::SEL_SEC:   level_evt = wrap; // [R4]
         rtcic_pkg::SEL_MIN:   level_evt = wrap && NEXT_MIN; // [R4]
         rtcic_pkg::SEL_HOUR:  level_evt = wrap && NEXT_HOUR; // [R4]
         rtcic_pkg::SEL_MONTH: level_evt = wrap && NEXT_MONTH; // [R4]
         default:              level_evt = 1'b0;
      endcase
   end

   // Periodic generator; low means irq_out_a pulled low
   always_comb begin
      case (c1_r.periodic_select)
         rtcic_pkg::SEL_OFF:   per_low_nxt = 1'b0; // [R3]
         rtcic_pkg::SEL_FIXED: per_low_nxt = 1'b1; // [R3]
         rtcic_pkg::SEL_2HZ:   per_low_nxt = !div_r[13] && !div_r[15]; // [R3]
         rtcic_pkg::SEL_1HZ:   per_low_nxt = div_r < 16'(rtcic_pkg::DIV_HALF + 16'(adj_win ? adj_clamped : 9'sh000)); // [R3] [R8]
         default: begin
            if (level_evt) begin
               per_low_nxt = 1'b1; // [R4] [R25]
            end else if (wr_c2 && !REG_WDATA[rtcic_pkg::C2_PER]) begin
               per_low_nxt = 1'b0; // [R16]
            end else begin
               per_low_nxt = per_low_r;
            end
         end
      endcase
      if (wr_sec && pulse_mode) begin
         per_low_nxt = 1'b1; // [R6]
      end
      if (halt_set || wr_c1) begin
         per_low_nxt = 1'b0; // [R13]
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         per_low_r <= 1'b0;
      end else begin
         per_low_r <= per_low_nxt;
      end
   end

   // Alarm delays from match to flag
   rtcic_delay #(
      .CYCLES (ALARM_DELAY)
   ) u_wa_delay (
      .clk   (CLK),
      .rst_b (RST_B),
      .start (ALARM_W_MATCH && c1_r.weekday_alarm_enable), // [R17] [R23]
      .abort (!c1_r.weekday_alarm_enable),
      .busy  (wa_busy),
      .done  (wa_done)
   );

   rtcic_delay #(
      .CYCLES (ALARM_DELAY)
   ) u_da_delay (
      .clk   (CLK),
      .rst_b (RST_B),
      .start (ALARM_D_MATCH && c1_r.daily_alarm_enable), // [R17] [R23]
      .abort (!c1_r.daily_alarm_enable),
      .busy  (da_busy),
      .done  (da_done)
   );

   always_comb begin
      waf_nxt = c2_r.weekday_alarm_flag;
      daf_nxt = c2_r.daily_alarm_flag;
      if (wr_c2 && !REG_WDATA[rtcic_pkg::C2_WAFL]) waf_nxt = 1'b0; // [R18]
      if (wr_c2 && !REG_WDATA[rtcic_pkg::C2_DAFL]) daf_nxt = 1'b0; // [R18]
      if (wa_done) waf_nxt = 1'b1; // [R17] [R25]
      if (da_done) daf_nxt = 1'b1; // [R17] [R25]
      if (!c1_r.weekday_alarm_enable || halt_set) waf_nxt = 1'b0; // [R19] [R13]
      if (!c1_r.daily_alarm_enable || halt_set) daf_nxt = 1'b0; // [R19] [R13]
   end

   // Control register 1
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         c1_r <= rtcic_pkg::CTRL1_RST;
      end else if (halt_set) begin
         c1_r <= rtcic_pkg::CTRL1_RST; // [R13] [R1]
      end else if (wr_c1) begin
         c1_r <= REG_WDATA; // [R24] [R2] [R23]
      end
   end

   // Control register 2; hardware sets win over same-cycle clears
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         c2_r <= rtcic_pkg::CTRL2_RST; // [R21]
      end else if (halt_set) begin
         c2_r <= rtcic_pkg::CTRL2_RST; // [R13] [R1] [R12]
      end else begin
         if (wr_c2) begin
            c2_r.voltage_threshold_select <= REG_WDATA[rtcic_pkg::C2_VSEL]; // [R9]
            c2_r.spare_bit_one            <= REG_WDATA[rtcic_pkg::C2_SPARE1]; // [R1]
            c2_r.spare_bit_two            <= REG_WDATA[rtcic_pkg::C2_SPARE2]; // [R1]
         end
         if (below) begin
            c2_r.low_voltage_flag <= 1'b1; // [R10] [R25]
         end else if (wr_c2 && !REG_WDATA[rtcic_pkg::C2_VLOW]) begin
            c2_r.low_voltage_flag <= 1'b0; // [R11]
         end
         if (wr_c2 && !REG_WDATA[rtcic_pkg::C2_HALT]) begin
            c2_r.osc_halt_flag <= 1'b0; // [R14]
         end
         c2_r.periodic_irq_flag  <= per_low_nxt; // [R15]
         c2_r.weekday_alarm_flag <= waf_nxt;
         c2_r.daily_alarm_flag   <= daf_nxt;
      end
   end

   // Pins follow the flags in the same cycle
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         IRQ_A_OE <= 1'b0;
         IRQ_B_OE <= 1'b0;
      end else begin
         IRQ_A_OE <= per_low_nxt || daf_nxt; // [R20] [R15]
         IRQ_B_OE <= waf_nxt; // [R20]
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         SUB_CLK_EN <= 1'b1;
         ADJ_CLEAR  <= 1'b0;
      end else begin
         ADJ_CLEAR <= halt_set; // [R13]
         if (halt_set) begin
            SUB_CLK_EN <= 1'b1; // [R13]
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         TEST_MODE   <= 1'b0;
         HOUR24_MODE <= 1'b0;
      end else begin
         TEST_MODE   <= halt_set ? 1'b0 : (wr_c1 ? REG_WDATA[rtcic_pkg::C1_TEST] : c1_r.test); // [R2]
         HOUR24_MODE <= halt_set ? 1'b0 : (wr_c1 ? REG_WDATA[rtcic_pkg::C1_HOUR24] : c1_r.hour24);
      end
   end

   // Read data; unlisted indices belong to the counters outside and read 0 here
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         REG_RDATA <= 8'h00;
      end else begin
         case (REG_ADDR)
            rtcic_pkg::ADDR_CTRL1: REG_RDATA <= c1_r; // [R24]
            rtcic_pkg::ADDR_CTRL2: REG_RDATA <= c2_r; // [R21]
            default:               REG_RDATA <= 8'h00;
         endcase
      end
   end

   property p_spare_clear;
      @(posedge CLK) disable iff (!RST_B)
      halt_set |=> (!c2_r.spare_bit_one && !c2_r.spare_bit_two && !c1_r.spare_bit_three && c2_r.osc_halt_flag);
   endproperty
   a_spare_clear: assert property (p_spare_clear) else $error("spare bits not cleared on halt"); // [R1]

   property p_fixed_low;
      @(posedge CLK) disable iff (!RST_B)
      (c1_r.periodic_select == rtcic_pkg::SEL_FIXED && !wr_c1 && !halt_set)[*2] |=> IRQ_A_OE;
   endproperty
   a_fixed_low: assert property (p_fixed_low) else $error("fixed low select did not hold output A low"); // [R3]

   property p_sec_write;
      @(posedge CLK) disable iff (!RST_B)
      wr_sec |=> (div_r == 16'h0000) && (pulse_mode -> per_low_r);
   endproperty
   a_sec_write: assert property (p_sec_write) else $error("seconds write did not restart divider"); // [R6]

   property p_level_edge;
      @(posedge CLK) disable iff (!RST_B)
      (level_mode && level_evt && !halt_set && !wr_c1) |=> (SEC_INC && per_low_r && IRQ_A_OE);
   endproperty
   a_level_edge: assert property (p_level_edge) else $error("level event not aligned to seconds increment"); // [R7]

   property p_vlow_hold;
      @(posedge CLK) disable iff (!RST_B)
      (c2_r.low_voltage_flag && !halt_set && !(wr_c2 && !REG_WDATA[rtcic_pkg::C2_VLOW])) |=> c2_r.low_voltage_flag;
   endproperty
   a_vlow_hold: assert property (p_vlow_hold) else $error("low-voltage flag dropped without clear"); // [R10]

   property p_vlow_set;
      @(posedge CLK) disable iff (!RST_B)
      (below && !halt_set) |=> c2_r.low_voltage_flag;
   endproperty
   a_vlow_set: assert property (p_vlow_set) else $error("low-voltage flag missed a drop"); // [R10]

   property p_halt_clear;
      @(posedge CLK) disable iff (!RST_B)
      (c2_r.osc_halt_flag && wr_c2 && !REG_WDATA[rtcic_pkg::C2_HALT]) |=> !c2_r.osc_halt_flag;
   endproperty
   a_halt_clear: assert property (p_halt_clear) else $error("halt flag not cleared by write of 0"); // [R14]

   property p_alarm_rise;
      @(posedge CLK) disable iff (!RST_B)
      $rose(c2_r.daily_alarm_flag) |-> $past(da_done) && $past(c1_r.daily_alarm_enable);
   endproperty
   a_alarm_rise: assert property (p_alarm_rise) else $error("daily alarm flag set without delay expiry"); // [R17]

   property p_alarm_off;
      @(posedge CLK) disable iff (!RST_B)
      !c1_r.weekday_alarm_enable |=> !c2_r.weekday_alarm_flag && !IRQ_B_OE && !wa_busy;
   endproperty
   a_alarm_off: assert property (p_alarm_off) else $error("weekday alarm flag set while disabled"); // [R19]

   property p_pin_track;
      @(posedge CLK) disable iff (!RST_B)
      (IRQ_A_OE == (c2_r.periodic_irq_flag || c2_r.daily_alarm_flag)) && (IRQ_B_OE == c2_r.weekday_alarm_flag);
   endproperty
   a_pin_track: assert property (p_pin_track) else $error("interrupt pins disagree with flags"); // [R20]

endmodule : rtcic_ctrl

/* testbench/rtcic_host.sv */
`timescale 1ns/10ps
// Register-port host: requests launch 1 ns after an edge and hold until the taking edge
module rtcic_host (
   input  wire logic       clk,        // System clock
   output logic      [3:0] reg_addr,   // Register index
   output logic            reg_wr,     // Write strobe
   output logic      [7:0] reg_wdata,  // Write data
   input  wire logic [7:0] reg_rdata   // Read data
);
   logic halt_seen;

   initial begin
      reg_addr  = 4'h0;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
      halt_seen = 1'b1;
   end

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr  = a;
      reg_wdata = (a == 4'hE) ? (d & 8'hF7) : d;
      reg_wr    = 1'b1;
      @(posedge clk);
      #1;
      reg_wr    = 1'b0;
      // Released data shows a changed pattern, not the last value
      reg_wdata = ~reg_wdata;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      @(posedge clk);
      #1;
      d = reg_rdata;
      if (a == 4'hF) halt_seen = d[4];
   endtask : rd
endmodule : rtcic_host

/* testbench/rtc_interrupt_status_control_test.sv */
`timescale 1ns/10ps
module rtc_interrupt_status_control_test;
   logic       clk, rst_b, tick, halt, bhi, blo, amw, amd, nmin, wr;
   logic       sec_inc, a_oe, b_oe, sub_en, adj_clr, test_m, h24;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, v, w, sp;
   int         miscompares, num_checks, cyc, k;

   rtcic_host u_host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rdata(rdata));
   rtcic_ctrl #(.SEC_DELAY(4), .ALARM_DELAY(3)) uut (
      .CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RDATA(rdata),
      .OSC_TICK(tick), .OSC_HALT(halt), .SUPPLY_BELOW_HI(bhi), .SUPPLY_BELOW_LO(blo),
      .ALARM_W_MATCH(amw), .ALARM_D_MATCH(amd), .NEXT_MIN(nmin), .NEXT_HOUR(1'b0), .NEXT_MONTH(1'b0),
      .ADJ_STEP(8'sh00), .SEC_INC(sec_inc), .IRQ_A_OE(a_oe), .IRQ_B_OE(b_oe), .SUB_CLK_EN(sub_en),
      .ADJ_CLEAR(adj_clr), .TEST_MODE(test_m), .HOUR24_MODE(h24));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   // One crystal second (32768 cycles) plus about 17000 cycles of pulse phases
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         give_verdict();
      end
   end

   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic rc(input logic [3:0] a, input logic [7:0] e, input string n);
      u_host.rd(a, v);
      chk(n, v, e);
   endtask : rc

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   // Ctrl2 after a write with all flags clear: only writable bits survive
   function automatic logic [7:0] f2(input logic [7:0] d);
      return {d[7], 1'b0, d[5], 1'b0, d[3], 3'b000};
   endfunction : f2

   initial begin
      {rst_b, tick, halt, bhi, blo, amw, amd, nmin} = 8'h00;
      sp = $urandom(32'h92F7);
      step(20);
      rst_b = 1'b1;
      rc(4'hF, 8'h10, "ctrl2_rst");
      rc(4'hE, 8'h00, "ctrl1_rst");
      rc(4'hD, 8'h00, "unmapped");
      u_host.wr(4'hF, 8'h00);
      rc(4'hF, 8'h00, "halt_clr");
      for (k = 0; k < 4; k++) begin
         sp = $urandom();
         w  = {sp[4], 1'b1, sp[0], 1'b1, sp[1], 3'b111};
         u_host.wr(4'hF, w);
         rc(4'hF, f2(w), "ctrl2_wr");
         w = {2'b00, sp[2], sp[3], 4'h0};
         u_host.wr(4'hE, w);
         rc(4'hE, w, "ctrl1_wr");
         chk("hour24", {7'h0, h24}, {7'h0, w[5]});
         chk("test", {7'h0, test_m}, 8'h00);
      end
      u_host.wr(4'hF, 8'h28);
      step(1);
      halt = 1'b1;
      step(1);
      chk("adj_clear", {7'h0, adj_clr}, 8'h01);
      halt = 1'b0;
      rc(4'hF, 8'h10, "halt_ctrl2");
      chk("halt_poll", {7'h0, u_host.halt_seen}, 8'h01);
      rc(4'hE, 8'h00, "halt_ctrl1");
      chk("subclk", {7'h0, sub_en}, 8'h01);
      chk("adj_clear_end", {7'h0, adj_clr}, 8'h00);
      u_host.wr(4'hF, 8'h00);
      for (k = 0; k < 2; k++) begin
         u_host.wr(4'hE, 8'(k));
         step(2);
         chk("irq_a_fixed", {7'h0, a_oe}, 8'(k));
         u_host.rd(4'hF, v);
         chk("per_flag", {7'h0, v[2]}, 8'(k));
      end
      // Pulse phases need the divider past its half-way points
      u_host.wr(4'h0, 8'h00);
      u_host.wr(4'hE, 8'h02);
      tick = 1'b1;
      step(9000);
      chk("irq_a_2hz_hi", {7'h0, a_oe}, 8'h00);
      u_host.wr(4'hE, 8'h03);
      step(2);
      chk("irq_a_1hz_lo", {7'h0, a_oe}, 8'h01);
      step(8000);
      chk("irq_a_1hz_hi", {7'h0, a_oe}, 8'h00);
      u_host.wr(4'h0, 8'h00);
      chk("sec_wr_low", {7'h0, a_oe}, 8'h01);
      nmin = 1'b1;
      u_host.wr(4'hE, 8'h05);
      k = 0;
      while (sec_inc !== 1'b1 && k < 40000) begin
         step(1);
         k++;
      end
      chk("sec_inc", {7'h0, sec_inc}, 8'h01);
      chk("lvl_irq_a", {7'h0, a_oe}, 8'h01);
      tick = 1'b0;
      nmin = 1'b0;
      u_host.rd(4'hF, v);
      chk("lvl_flag", {7'h0, v[2]}, 8'h01);
      u_host.wr(4'hF, 8'h00);
      step(1);
      chk("lvl_release", {7'h0, a_oe}, 8'h00);
      u_host.wr(4'hE, 8'hC0);
      amd = 1'b1;
      step(1);
      amd = 1'b0;
      amw = 1'b1;
      step(1);
      amw = 1'b0;
      step(6);
      chk("alarm_pins", {6'h0, b_oe, a_oe}, 8'h03);
      rc(4'hF, 8'h03, "alarm_flags");
      u_host.wr(4'hF, 8'h01);
      step(1);
      chk("alarm_clr", {6'h0, b_oe, a_oe}, 8'h01);
      u_host.wr(4'hE, 8'h00);
      rc(4'hF, 8'h00, "alarm_off");
      bhi = 1'b1;
      step(1);
      bhi = 1'b0;
      rc(4'hF, 8'h40, "vlow_hold");
      u_host.wr(4'hF, 8'h80);
      rc(4'hF, 8'h80, "vlow_clr");
      bhi = 1'b1;
      step(3);
      bhi = 1'b0;
      rc(4'hF, 8'h80, "vsel_hi_ign");
      blo = 1'b1;
      step(1);
      blo = 1'b0;
      rc(4'hF, 8'hC0, "vsel_lo");
      give_verdict();
   end
endmodule : rtc_interrupt_status_control_test
